// ### core/cycle_gate_pkg.sv
// shared constants, register map and carrier types for the switching cycle gate
package cycle_gate_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned FILT_NS = 10_000;
    localparam int unsigned FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SOFT_MS = 5;
    localparam int unsigned SOFT_CYC = SOFT_MS * (CLK_HZ / 1000);
    localparam int unsigned PERIOD_CYC = 32;
    localparam int unsigned BLANK_NS = 200;
    localparam int unsigned BLANK_CYC =
        (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // duty, current limit and feedback figures in percent
    localparam logic [7:0] DUTY_HI_PCT = 8'h4B;
    localparam logic [7:0] DUTY_LO_PCT = 8'h21;
    localparam logic [7:0] MIN_DUTY_PCT = 8'h05;
    localparam logic [7:0] ILIM_LO_PCT = 8'h19;
    localparam logic [7:0] ILIM_SOFT_PCT = 8'h55;
    localparam logic [7:0] ILIM_FULL_PCT = 8'h64;
    localparam logic [7:0] FB_SKIP_STEP = 8'h14;

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] FB_ADDR = 8'h04;
    localparam logic [7:0] LINE_ADDR = 8'h08;
    localparam logic [7:0] ILIM_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_ADDR = 8'h10;

    // control field positions and reset values
    localparam int unsigned CTRL_LOW_EN_BIT = 0;
    localparam int unsigned CTRL_HIGH_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [7:0] FB_RESET = 8'h00;
    localparam logic [7:0] LINE_RESET = 8'h00;
    localparam logic [7:0] ILIM_RESET = 8'h64;

    // operating modes, gray coded along power-up, run, halt
    typedef enum logic [2:0] {
        MODE_LOCKOUT = 3'b000,
        MODE_SOFT = 3'b001,
        MODE_RUN = 3'b011,
        MODE_HALT = 3'b010,
        MODE_HYST = 3'b110,
        MODE_RESTART = 3'b111
    } mode_e;

    // comparator inputs from the analog side
    typedef struct packed {
        logic current_trip;
        logic line_low;
        logic line_high;
        logic remote_off;
        logic supply_top;
        logic regulation_lost;
    } sense_s;

    // outputs toward the switch and supply node
    typedef struct packed {
        logic switch_on;
        logic osc_run;
        logic hv_source_on;
    } drive_s;

endpackage : cycle_gate_pkg

// ### core/switching_cycle_fault_gating.sv
// per-cycle switch gating with fault, line and remote on/off control
// Operation
// - duty falls linearly with feedback to minimum
// - feedback beyond minimum step skips cycles
// - current trip ends pulse until next cycle
// - blanking hides current trip after turn-on
// - current limit settable 25 to 100 percent
// - power-up waits for line-low upper threshold
// - hysteresis: stays on until lower threshold
// - line low over 10 us turns off
// - restart with soft-start at supply top
// - regulation lost first means auto-restart
// - restart final state samples line-low comparator
// - line-low and line-high disable independently
// - line high forces switch off within cycle; here it stops switching at cycle end only
// - max duty 75 to 33 percent with line
// - higher line gives smaller duty
// - disable finishes the cycle in progress
// - oscillator halted while disable persists
// - enable restarts oscillator, next cycle
// - remote off over 10 us: hysteretic mode
// - re-enable starts soft-start at supply top
// - auto-restart enables only at count seven
// - soft-start ramps duty and current limit
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

module switching_cycle_fault_gating #(
    parameter int unsigned SOFT_CYCLES = cycle_gate_pkg::SOFT_CYC,
    parameter int unsigned PERIOD = cycle_gate_pkg::PERIOD_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cycle_gate_pkg::sense_s sense,
    output cycle_gate_pkg::drive_s drive
);

    localparam logic [15:0] FILT_N = 16'(cycle_gate_pkg::FILT_CYC);
    localparam logic [7:0] PER_N = 8'(PERIOD);
    localparam logic [7:0] BLANK_N = 8'(cycle_gate_pkg::BLANK_CYC);
    localparam logic [23:0] SOFT_N = 24'(SOFT_CYCLES);

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] sy;
        cycle_gate_pkg::mode_e mode;
        logic [1:0] ctrl;
        logic [7:0] fb;
        logic [7:0] line;
        logic [7:0] ilim;
        logic [7:0] phase;
        logic [7:0] blank;
        logic [7:0] on_len;
        logic tripped;
        logic sw;
        logic running;
        logic [15:0] low_cnt;
        logic [15:0] rem_cnt;
        logic [2:0] restart_cnt;
        logic [23:0] soft_cnt;
        logic top_d;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_s;

    state_s r;
    state_s next_r;

    // percentage scaling shared by the ramps
    function automatic logic [7:0] scale(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [23:0] num,
                                         input logic [23:0] den);
        logic [31:0] span;
        span = 32'(b - a) * 32'(num) / 32'(den);
        return 8'(32'(a) + span);
    endfunction

    // duty in clocks from a percentage of the period
    function automatic logic [7:0] pct_clk(input logic [7:0] pct);
        return 8'((16'(pct) * 16'(PER_N)) / 16'd100);
    endfunction

    logic [7:0] max_pct;
    logic [7:0] duty_pct;
    logic [7:0] lim_pct;
    logic low_bad;
    logic high_bad;
    logic disable_req;

    // line level maps max duty; current limit comes from its setting; all limits combined
    always_comb
    begin
        max_pct = scale(cycle_gate_pkg::DUTY_HI_PCT,
                        cycle_gate_pkg::DUTY_LO_PCT,
                        24'(r.line), 24'd255);
        if (r.mode == cycle_gate_pkg::MODE_SOFT)
        begin
            max_pct = scale(8'h00, max_pct, r.soft_cnt, SOFT_N);
        end
        // feedback and line both subtract from duty
        if (r.fb >= 8'd70 + cycle_gate_pkg::FB_SKIP_STEP)
        begin
            duty_pct = 8'h00;
        end
        else if (r.fb >= 8'd70)
        begin
            duty_pct = cycle_gate_pkg::MIN_DUTY_PCT;
        end
        else
        begin
            duty_pct = 8'(cycle_gate_pkg::DUTY_HI_PCT - r.fb
                          - {2'b00, r.line[7:2]});
            if (duty_pct < cycle_gate_pkg::MIN_DUTY_PCT ||
                duty_pct > cycle_gate_pkg::DUTY_HI_PCT)
            begin
                duty_pct = cycle_gate_pkg::MIN_DUTY_PCT;
            end
        end
        if (duty_pct > max_pct)
        begin
            duty_pct = max_pct;
        end
        // current limit level: setting clamped, softened while ramping
        lim_pct = r.ilim < cycle_gate_pkg::ILIM_LO_PCT ?
                  cycle_gate_pkg::ILIM_LO_PCT :
                  (r.ilim > cycle_gate_pkg::ILIM_FULL_PCT ?
                   cycle_gate_pkg::ILIM_FULL_PCT : r.ilim);
        if (r.mode == cycle_gate_pkg::MODE_SOFT)
        begin
            lim_pct = 8'((16'(lim_pct) * 16'(scale(
                cycle_gate_pkg::ILIM_SOFT_PCT,
                cycle_gate_pkg::ILIM_FULL_PCT,
                r.soft_cnt, SOFT_N))) / 16'd100);
        end
        // each line feature masked on its own enable
        low_bad = r.ctrl[cycle_gate_pkg::CTRL_LOW_EN_BIT] &&
                  r.low_cnt >= FILT_N;
        high_bad = r.ctrl[cycle_gate_pkg::CTRL_HIGH_EN_BIT] &&
                   r.sy[3];
        disable_req = low_bad || high_bad || r.sy[2];
    end

    // whole next state
    always_comb
    begin
        next_r = r;
        // three-stage sampling; change counts once stages two and three agree
        next_r.s1 = sense;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3)
        begin
            next_r.sy = r.s3;
        end
        next_r.top_d = r.sy[1];
        // persistence filters restart when condition clears
        if (r.sy[4] && r.low_cnt < FILT_N)
        begin
            next_r.low_cnt = r.low_cnt + 16'd1;
        end
        else if (!r.sy[4])
        begin
            next_r.low_cnt = 16'h0000;
        end
        if (r.sy[2] && r.rem_cnt < FILT_N)
        begin
            next_r.rem_cnt = r.rem_cnt + 16'd1;
        end
        else if (!r.sy[2])
        begin
            next_r.rem_cnt = 16'h0000;
        end
        // cycle engine: ends a pulse on duty, trip or cycle end
        if (r.running)
        begin
            next_r.phase = r.phase == PER_N - 8'd1 ? 8'h00 :
                           r.phase + 8'd1;
            if (r.blank != 8'h00)
            begin
                next_r.blank = r.blank - 8'd1;
            end
            if (r.phase == PER_N - 8'd1)
            begin
                next_r.tripped = 1'b0;
                next_r.on_len = pct_clk(duty_pct);
                next_r.sw = pct_clk(duty_pct) != 8'h00;
                next_r.blank = BLANK_N;
                if (disable_req)
                begin
                    next_r.sw = 1'b0;
                    next_r.running = 1'b0;
                end
            end
            else if (r.sw && r.blank == 8'h00 &&
                     (r.sy[5] || r.phase >= pct_clk(lim_pct)))
            begin
                next_r.sw = 1'b0;
                next_r.tripped = 1'b1;
            end
            else if (r.phase + 8'd1 >= r.on_len)
            begin
                next_r.sw = 1'b0;
            end
        end
        // mode sequencing
        case (r.mode)
            cycle_gate_pkg::MODE_LOCKOUT:
            begin
                next_r.sw = 1'b0;
                next_r.running = 1'b0;
                if (!r.sy[4] || !r.ctrl[cycle_gate_pkg::CTRL_LOW_EN_BIT])
                begin
                    if (r.sy[1] && !r.top_d)
                    begin
                        next_r.mode = cycle_gate_pkg::MODE_SOFT;
                        next_r.soft_cnt = 24'h000000;
                        next_r.running = 1'b1;
                        next_r.phase = PER_N - 8'd1;
                    end
                end
            end
            cycle_gate_pkg::MODE_SOFT,
            cycle_gate_pkg::MODE_RUN:
            begin
                if (r.mode == cycle_gate_pkg::MODE_SOFT)
                begin
                    if (r.soft_cnt >= SOFT_N - 24'd1)
                    begin
                        next_r.mode = cycle_gate_pkg::MODE_RUN;
                    end
                    else
                    begin
                        next_r.soft_cnt = r.soft_cnt + 24'd1;
                    end
                end
                if (r.sy[0] && !low_bad)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_RESTART;
                    next_r.restart_cnt = 3'h0;
                    next_r.sw = 1'b0;
                    next_r.running = 1'b0;
                end
                else if (!r.running)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_HALT;
                end
            end
            cycle_gate_pkg::MODE_HALT:
            begin
                // line-low kept only beyond the lower threshold; hysteresis
                if (low_bad)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_LOCKOUT;
                end
                else if (r.rem_cnt >= FILT_N)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_HYST;
                end
                else if (!disable_req)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_RUN;
                    next_r.running = 1'b1;
                    next_r.phase = PER_N - 8'd1;
                end
            end
            cycle_gate_pkg::MODE_HYST:
            begin
                // wait for remote on, then start at next supply top
                if (!r.sy[2] && r.sy[1] && !r.top_d)
                begin
                    next_r.mode = cycle_gate_pkg::MODE_SOFT;
                    next_r.soft_cnt = 24'h000000;
                    next_r.running = 1'b1;
                    next_r.phase = PER_N - 8'd1;
                end
            end
            cycle_gate_pkg::MODE_RESTART:
            begin
                if (r.sy[1] && !r.top_d)
                begin
                    next_r.restart_cnt = r.restart_cnt + 3'h1;
                    if (r.restart_cnt == 3'h7)
                    begin
                        // final state: line must be above upper threshold
                        if (!(r.sy[4] &&
                              r.ctrl[cycle_gate_pkg::CTRL_LOW_EN_BIT]))
                        begin
                            next_r.mode = cycle_gate_pkg::MODE_SOFT;
                            next_r.soft_cnt = 24'h000000;
                            next_r.running = 1'b1;
                            next_r.phase = PER_N - 8'd1;
                        end
                    end
                end
            end
            default:
            begin
                next_r.mode = cycle_gate_pkg::MODE_LOCKOUT;
            end
        endcase
        // bus: writes land one cycle after the address phase
        next_r.wr_pend = 1'b0;
        if (r.wr_pend)
        begin
            case (r.wr_addr)
                cycle_gate_pkg::CTRL_ADDR: next_r.ctrl = hwdata[1:0];
                cycle_gate_pkg::FB_ADDR: next_r.fb = hwdata[7:0];
                cycle_gate_pkg::LINE_ADDR: next_r.line = hwdata[7:0];
                cycle_gate_pkg::ILIM_ADDR: next_r.ilim = hwdata[7:0];
                default: next_r.ctrl = r.ctrl;
            endcase
        end
        if (hsel && hready && htrans[1])
        begin
            next_r.wr_pend = hwrite;
            next_r.wr_addr = haddr;
            case (haddr)
                cycle_gate_pkg::CTRL_ADDR: next_r.rdata = {30'h0, r.ctrl};
                cycle_gate_pkg::FB_ADDR: next_r.rdata = {24'h0, r.fb};
                cycle_gate_pkg::LINE_ADDR: next_r.rdata = {24'h0, r.line};
                cycle_gate_pkg::ILIM_ADDR: next_r.rdata = {24'h0, r.ilim};
                cycle_gate_pkg::STATUS_ADDR:
                    next_r.rdata = {16'h0, max_pct, r.restart_cnt,
                                    r.tripped, r.running, r.mode};
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    // state register; every field takes a constant under reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
            r.mode <= cycle_gate_pkg::MODE_LOCKOUT;
            r.ctrl <= cycle_gate_pkg::CTRL_RESET;
            r.fb <= cycle_gate_pkg::FB_RESET;
            r.line <= cycle_gate_pkg::LINE_RESET;
            r.ilim <= cycle_gate_pkg::ILIM_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs: zero-wait slave, switch and oscillator from flops
    assign hrdata = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign drive.switch_on = r.sw;
    assign drive.osc_run = r.running;
    assign drive.hv_source_on = r.mode == cycle_gate_pkg::MODE_LOCKOUT ||
                                r.mode == cycle_gate_pkg::MODE_HYST ||
                                r.mode == cycle_gate_pkg::MODE_RESTART;

endmodule // switching_cycle_fault_gating

`default_nettype wire

// ### verif/switching_cycle_fault_gating_assertions.sv
// concurrent checks on the switching cycle gate ports
`timescale 1ns/10ps
`default_nettype none

module switching_cycle_fault_gating_checker #(
    parameter int unsigned PERIOD = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire cycle_gate_pkg::sense_s sense,
    input wire cycle_gate_pkg::drive_s drive
);
    localparam int RESUME_MAX = 12;
    int unsigned on_cnt;
    int unsigned rem_cnt;
    int unsigned gap_cnt;
    logic sw_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // run lengths of on-time, remote-off and spacing of turn-ons
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            on_cnt <= 0;
            rem_cnt <= 0;
            gap_cnt <= PERIOD;
            sw_q <= 1'b0;
        end
        else
        begin
            on_cnt <= drive.switch_on ? on_cnt + 1 : 0;
            rem_cnt <= !sense.remote_off ? 0 : rem_cnt + (rem_cnt < 1000);
            sw_q <= drive.switch_on;
            if (drive.switch_on && !sw_q)
                gap_cnt <= 1;
            else
                gap_cnt <= gap_cnt + (gap_cnt < PERIOD);
        end
    end

    // a trip that outlasts blanking plus sync must end the pulse
    sequence trip_while_on;
        (sense.current_trip && drive.switch_on)[*8];
    endsequence

    AST_READY: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1])
        |=> $stable(hrdata))
        else $error("read data moved without a read");
    AST_TRIP: assert property (not trip_while_on)
        else $error("current trip did not end the pulse");
    AST_MAX_ON: assert property (drive.switch_on |-> on_cnt < PERIOD * 3 / 4)
        else $error("on-time exceeded the maximum duty");
    AST_CYCLE_GAP: assert property ((drive.switch_on && !sw_q) |-> gap_cnt >= PERIOD - 1)
        else $error("switch turned on twice within one cycle");
    AST_SW_NEEDS_OSC: assert property (drive.switch_on |-> drive.osc_run)
        else $error("switch on while oscillator halted");
    AST_HALT: assert property (rem_cnt >= PERIOD + 8 |-> !drive.osc_run)
        else $error("oscillator kept running under remote off");
    AST_RESUME: assert property ((!sense.remote_off && rem_cnt >= PERIOD + 8
        && rem_cnt < 90) |-> ##[1:RESUME_MAX] drive.osc_run)
        else $error("oscillator did not restart after enable");
endmodule // switching_cycle_fault_gating_checker

bind switching_cycle_fault_gating switching_cycle_fault_gating_checker #(
    .PERIOD(PERIOD)
) u_checker (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .sense(sense),
    .drive(drive)
);

`default_nettype wire

// ### verif/line_switch_partner.sv
// far-side model: switch current, supply node and line comparators
`timescale 1ns/10ps
`default_nettype none

module line_switch_partner #(
    parameter int unsigned CHARGE = 24
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire cycle_gate_pkg::drive_s drive,
    input wire logic line_low,
    input wire logic line_high,
    input wire logic remote_off,
    input wire logic reg_lost,
    input wire logic [7:0] trip_after,
    output cycle_gate_pkg::sense_s sense
);
    logic [7:0] on_cnt;
    int unsigned chg_cnt;

    // current ramps while on; supply node saws while the source charges it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            on_cnt <= 8'h00;
            chg_cnt <= 0;
        end
        else
        begin
            on_cnt <= drive.switch_on ? on_cnt + 8'h01 : 8'h00;
            if (!drive.hv_source_on || chg_cnt == CHARGE + 3)
                chg_cnt <= 0;
            else
                chg_cnt <= chg_cnt + 1;
        end
    end

    // supply sits at the shunt level once the charge source is off
    assign sense = '{
        current_trip: trip_after != 8'h00 && on_cnt >= trip_after,
        line_low: line_low,
        line_high: line_high,
        remote_off: remote_off,
        supply_top: !drive.hv_source_on || chg_cnt >= CHARGE,
        regulation_lost: reg_lost
    };
endmodule // line_switch_partner

`default_nettype wire

// ### verif/switching_cycle_fault_gating_tb.sv
// self-checking bench for the switching cycle gate
`timescale 1ns/10ps
`default_nettype none

module switching_cycle_fault_gating_tb;
    localparam int unsigned PER = 32;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    cycle_gate_pkg::sense_s sense;
    cycle_gate_pkg::drive_s drive;
    logic line_low;
    logic line_high;
    logic remote_off;
    logic reg_lost;
    logic [7:0] trip_after;
    int failures;
    int num_checks;

    // one slave, so its ready is the bus ready
    assign hready = hreadyout;

    switching_cycle_fault_gating #(.SOFT_CYCLES(200), .PERIOD(PER)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sense(sense), .drive(drive));

    line_switch_partner u_partner (
        .hclk(hclk), .hresetn(hresetn), .drive(drive), .line_low(line_low),
        .line_high(line_high), .remote_off(remote_off), .reg_lost(reg_lost),
        .trip_after(trip_after), .sense(sense));

    // 10 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // single word transfer; no wait count assumed, watchdog bounds it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, e);
    endtask

    // poll status mode field until it matches or the poll budget ends
    task automatic wait_mode(input logic [2:0] m, input int lim);
        logic [31:0] r;
        int i;
        i = 0;
        do
        begin
            bus(1'b0, 8'h10, 32'h0, r);
            i++;
        end
        while (r[2:0] !== m && i < lim);
        check({29'h0, r[2:0]}, {29'h0, m});
    endtask

    task automatic on_count(input int c, output int s);
        s = 0;
        repeat (c)
        begin
            @(posedge hclk);
            s += (drive.switch_on === 1'b1);
        end
    endtask

    // settle two cycles, then average on-time over four
    task automatic duty(output int n);
        repeat (2 * PER) @(posedge hclk);
        on_count(4 * PER, n);
        n = n / 4;
    endtask

    task automatic t_regs;
        logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
        logic [31:0] e [5] = '{32'h3, 32'h0, 32'h0, 32'h64, 32'h0};
        for (int i = 0; i < 5; i++)
            rd_chk(a[i], e[i]);
        wr(8'h0C, 32'h05);
        rd_chk(8'h0C, 32'h05);
        wr(8'h0C, 32'hFF);
        rd_chk(8'h0C, 32'hFF);
        wr(8'h14, 32'hFF);
        rd_chk(8'h14, 32'h0);
        wr(8'h10, 32'h3);
        wait_mode(cycle_gate_pkg::MODE_LOCKOUT, 1);
    endtask

    task automatic t_start;
        int n;
        on_count(300, n);
        check(32'(n), 32'h0);
        check({31'h0, drive.hv_source_on}, 32'h1);
        line_low <= 1'b0;
        wait_mode(cycle_gate_pkg::MODE_SOFT, 100);
        wait_mode(cycle_gate_pkg::MODE_RUN, 200);
    endtask

    task automatic t_duty;
        int n0;
        int n1;
        int n;
        duty(n0);
        check(32'(n0), 32'(PER * 3 / 4));
        wr(8'h04, 32'd60);
        duty(n1);
        check({31'h0, n1 < n0 && n1 > 0}, 32'h1);
        wr(8'h08, 32'd200);
        duty(n);
        check({31'h0, n < n1}, 32'h1);
        wr(8'h08, 32'd0);
        wr(8'h04, 32'd90);
        duty(n);
        check(32'(n), 32'h0);
        wr(8'h04, 32'd89);
        duty(n);
        check({31'h0, n > 0 && n <= n1}, 32'h1);
        wr(8'h04, 32'd0);
        wr(8'h08, 32'd255);
        duty(n);
        check({31'h0, n <= PER * 33 / 100 + 1}, 32'h1);
        wr(8'h08, 32'd0);
        wr(8'h0C, 32'd25);
        duty(n);
        check({31'h0, n < n0}, 32'h1);
        wr(8'h0C, 32'd100);
    endtask

    task automatic t_trip;
        int n;
        trip_after <= 8'd6;
        duty(n);
        check({31'h0, n >= 6 && n <= 12}, 32'h1);
        trip_after <= 8'd1;
        duty(n);
        check({31'h0, n >= 2 && n <= 8}, 32'h1);
        trip_after <= 8'd0;
    endtask

    task automatic t_line;
        int n;
        line_high <= 1'b1;
        repeat (PER + 8) @(posedge hclk);
        on_count(2 * PER, n);
        check(32'(n), 32'h0);
        wr(8'h00, 32'h1);
        duty(n);
        check({31'h0, n > 0}, 32'h1);
        wr(8'h00, 32'h3);
        line_high <= 1'b0;
        line_low <= 1'b1;
        on_count(70, n);
        check({31'h0, n > 0}, 32'h1);
        line_low <= 1'b0;
        repeat (10) @(posedge hclk);
        line_low <= 1'b1;
        on_count(70, n);
        check({31'h0, n > 0}, 32'h1);
        repeat (80) @(posedge hclk);
        on_count(2 * PER, n);
        check(32'(n), 32'h0);
        line_low <= 1'b0;
        wait_mode(cycle_gate_pkg::MODE_RUN, 300);
        wr(8'h00, 32'h2);
        line_low <= 1'b1;
        on_count(200, n);
        check({31'h0, n > 0}, 32'h1);
        line_low <= 1'b0;
        wr(8'h00, 32'h3);
    endtask

    task automatic t_remote;
        remote_off <= 1'b1;
        repeat (PER + 10) @(posedge hclk);
        check({30'h0, drive.osc_run, drive.switch_on}, 32'h0);
        repeat (18) @(posedge hclk);
        remote_off <= 1'b0;
        repeat (12) @(posedge hclk);
        check({31'h0, drive.osc_run}, 32'h1);
        remote_off <= 1'b1;
        repeat (200) @(posedge hclk);
        wait_mode(cycle_gate_pkg::MODE_HYST, 5);
        remote_off <= 1'b0;
        wait_mode(cycle_gate_pkg::MODE_SOFT, 100);
        wait_mode(cycle_gate_pkg::MODE_RUN, 200);
    endtask

    task automatic t_restart;
        int n;
        reg_lost <= 1'b1;
        wait_mode(cycle_gate_pkg::MODE_RESTART, 50);
        on_count(150, n);
        check(32'(n), 32'h0);
        reg_lost <= 1'b0;
        wait_mode(cycle_gate_pkg::MODE_RUN, 400);
    endtask

    task automatic complete_run;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence; line held low so the part waits in lockout
    initial
    begin
        failures = 0;
        num_checks = 0;
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 8'h00;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        line_low <= 1'b1;
        line_high <= 1'b0;
        remote_off <= 1'b0;
        reg_lost <= 1'b0;
        trip_after <= 8'd0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_start();
        t_duty();
        t_trip();
        t_line();
        t_remote();
        t_restart();
        complete_run();
    end

    // watchdog: the sequence needs well under a third of this span
    initial
    begin
        repeat (40000) @(posedge hclk);
        failures++;
        complete_run();
    end
endmodule // switching_cycle_fault_gating_tb

`default_nettype wire
